// >>> common/dbts_pkg.sv
// constants and types shared by the dma transfer sequencer
package dbts_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CH0_SRC_H = 8'h34;
  localparam logic [7:0] IDX_CH0_SRC_L = 8'h35;
  localparam logic [7:0] IDX_CH0_DST_H = 8'h36;
  localparam logic [7:0] IDX_CH0_DST_L = 8'h37;
  localparam logic [7:0] IDX_CH0_CTRL = 8'h38;
  localparam logic [7:0] IDX_CH0_BLEN = 8'h39;
  localparam logic [7:0] IDX_CH0_BCNT = 8'h3b;
  localparam logic [7:0] IDX_CH1_SRC_H = 8'h3c;
  localparam logic [7:0] IDX_CH1_SRC_L = 8'h3d;
  localparam logic [7:0] IDX_CH1_DST_H = 8'h3e;
  localparam logic [7:0] IDX_CH1_DST_L = 8'h3f;
  localparam logic [7:0] IDX_CH1_CTRL = 8'h40;
  localparam logic [7:0] IDX_CH1_BLEN = 8'h41;
  localparam logic [7:0] IDX_CH1_BCNT = 8'h43;
  localparam logic [7:0] IDX_CH2_SRC_H = 8'h44;
  localparam logic [7:0] IDX_CH2_SRC_L = 8'h45;
  localparam logic [7:0] IDX_CH2_DST_H = 8'h46;
  localparam logic [7:0] IDX_CH2_DST_L = 8'h47;
  localparam logic [7:0] IDX_CH2_CTRL = 8'h48;
  localparam logic [7:0] IDX_CH2_BLEN = 8'h49;
  localparam logic [7:0] IDX_CH2_BCNT = 8'h4b;
  localparam logic [7:0] IDX_GCTL1 = 8'h4c;
  localparam logic [7:0] IDX_GSTAT = 8'h4d;
  localparam logic [7:0] IDX_GCTL2 = 8'h4e;
  localparam logic [7:0] CH_STRIDE = IDX_CH1_SRC_H - IDX_CH0_SRC_H;
  localparam logic [7:0] SUB_SRC_L = IDX_CH0_SRC_L - IDX_CH0_SRC_H;
  localparam logic [7:0] SUB_DST_H = IDX_CH0_DST_H - IDX_CH0_SRC_H;
  localparam logic [7:0] SUB_DST_L = IDX_CH0_DST_L - IDX_CH0_SRC_H;
  localparam logic [7:0] SUB_CTRL = IDX_CH0_CTRL - IDX_CH0_SRC_H;
  localparam logic [7:0] SUB_BLEN = IDX_CH0_BLEN - IDX_CH0_SRC_H;
  localparam logic [7:0] SUB_BCNT = IDX_CH0_BCNT - IDX_CH0_SRC_H;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_SRC_MODE_LSB = 6;
  localparam int CTRL_DST_MODE_LSB = 4;
  localparam int CTRL_BWS_BIT = 3;
  localparam int GSTAT_IFC_LSB = 0;
  localparam int NUM_CH = 3;
  localparam int NUM_SRC = 8;
  localparam logic [1:0] MODE_STATIC = 2'h0;
  localparam logic [1:0] MODE_INC = 2'h1;
  localparam logic [1:0] MODE_DEC = 2'h2;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h00000000;
  // ---------------------------------------------------------------
  // sequencer states, one per bus state of a transfer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_DETECT, ST_ARB, ST_CTRL, ST_SCALC, ST_SRD, ST_LATCH,
    ST_DWR, ST_WDRV, ST_HSRD, ST_HLATCH, ST_HDWR, ST_HWDRV,
    ST_REL_A, ST_REL_D
  } dbts_state_t;
endpackage : dbts_pkg

// >>> common/dbts_arb_if.sv
// channel request and grant between sequencer and arbiter
`timescale 1ns/1ps
interface dbts_arb_if;
  logic [2:0] req;
  logic go;
  logic [1:0] gnt_ch;
  logic gnt_vld;
  modport arb (input req, input go, output gnt_ch, output gnt_vld);
  modport seq (output req, output go, input gnt_ch, input gnt_vld);
endinterface : dbts_arb_if

// >>> hdl/dbts_arb.sv
// fixed priority channel arbiter, channel 0 highest
`timescale 1ns/1ps
module dbts_arb
  import dbts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dbts_arb_if.arb ai
);
  // ---------------------------------------------------------------
  // grant register
  // ---------------------------------------------------------------
  logic [1:0] gnt_ch_q;
  logic gnt_vld_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gnt_ch_q <= 2'h0;
      gnt_vld_q <= 1'b0;
    end else if (ai.go) begin
      gnt_vld_q <= |ai.req;
      if (ai.req[0]) begin
        gnt_ch_q <= 2'h0;
      end else if (ai.req[1]) begin
        gnt_ch_q <= 2'h1;
      end else begin
        gnt_ch_q <= 2'h2;
      end
    end
  end

  assign ai.gnt_ch = gnt_ch_q;
  assign ai.gnt_vld = gnt_vld_q;
endmodule : dbts_arb

// >>> hdl/dbts_seq.sv
// three channel dma transfer sequencer with apb registers
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// [RQ1] take address, data, rw bus from cpu
// [RQ2] hold cpu clock stopped during transfer
// [RQ3] cpu state untouched, resumes after release
// [RQ4] states 1-3: detect, arbitrate, control
// [RQ5] state 4: compute and latch source address
// [RQ6] state 5: source read, latch destination
// [RQ7] state 6: latch data, count byte
// [RQ8] state 7: destination write, length minus count
// [RQ9] zero difference clears channel transfer enable
// [RQ10] zero difference with irq enable interrupts
// [RQ11] state 8: drive data, complete write
// [RQ12] release address/rw in 9, data in 10
// [RQ13] word: same start, low source address
// [RQ14] word 5-7: low byte read and write
// [RQ15] word 8: drive low data, high source
// [RQ16] word 9-10: high read, latch, count
// [RQ17] word 11: high write, completion check
// [RQ18] word 12 write, release 13 and 14
// [RQ19] byte ten states, word fourteen states
// [RQ20] software picks byte or word per channel
// [RQ21] word length programmed as twice words
// [RQ22] cpu clock stop changes glitch free
module dbts_seq
  import dbts_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] XFER_SRC_REQ,
  input wire logic [7:0] DATA_BUS_IN,
  output logic [15:0] ADDR_BUS_OUT,
  output logic ADDR_BUS_OE,
  output logic RW_OUT,
  output logic RW_OE,
  output logic [7:0] DATA_BUS_OUT,
  output logic DATA_BUS_OE,
  output logic CPU_CLK_STOP,
  output logic CPU_IRQ
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] src_h_q [NUM_CH];
  logic [7:0] src_l_q [NUM_CH];
  logic [7:0] dst_h_q [NUM_CH];
  logic [7:0] dst_l_q [NUM_CH];
  logic [7:0] ctrl_q [NUM_CH];
  logic [7:0] blen_q [NUM_CH];
  logic [7:0] bcnt_q [NUM_CH];
  logic [7:0] gctl1_q;
  logic [7:0] gstat_q;
  logic [7:0] gctl2_q;
  logic [7:0] req_s1_q;
  logic [7:0] req_s2_q;
  dbts_state_t state_q;
  dbts_state_t state_d;
  logic [1:0] ch_q;
  logic word_q;
  logic [15:0] src_tmp_q;
  logic [15:0] dst_tmp_q;
  logic [7:0] data_tmp_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [15:0] addr_q;
  logic addr_oe_q;
  logic rw_q;
  logic [7:0] data_q;
  logic data_oe_q;
  logic clk_stop_q;
  logic irq_q;
  logic [2:0] ch_req;
  logic seq_inc;
  logic seq_chk;
  logic diff_zero;
  logic [15:0] src_calc;
  logic [15:0] dst_calc;
  logic apb_acc;
  logic apb_wr;
  logic [7:0] idx;
  logic [7:0] wbyte;

  dbts_arb_if ai ();

  dbts_arb u_arb (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .ai(ai)
  );

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] addr_calc(input logic [7:0] hi,
      input logic [7:0] lo, input logic [1:0] mode, input logic [7:0] cnt);
    logic [15:0] base;
    base = {hi, lo};
    if (mode == MODE_INC) begin
      addr_calc = base + {8'h00, cnt};
    end else if (mode == MODE_DEC) begin
      addr_calc = base - {8'h00, cnt};
    end else begin
      addr_calc = base;
    end
  endfunction : addr_calc

  function automatic logic is_chan(input logic [7:0] i);
    is_chan = (i >= IDX_CH0_SRC_H) && (i < IDX_GCTL1);
  endfunction : is_chan

  function automatic logic [1:0] chan_of(input logic [7:0] i);
    logic [7:0] rel;
    rel = i - IDX_CH0_SRC_H;
    chan_of = 2'(rel / CH_STRIDE);
  endfunction : chan_of

  function automatic logic [7:0] sub_of(input logic [7:0] i);
    logic [7:0] rel;
    rel = i - IDX_CH0_SRC_H;
    sub_of = rel % CH_STRIDE;
  endfunction : sub_of

  function automatic logic tec_of(input logic [7:0] g, input logic [1:0] c);
    tec_of = g[{c, 1'b1}];
  endfunction : tec_of

  function automatic logic iec_of(input logic [7:0] g, input logic [1:0] c);
    iec_of = g[{c, 1'b0}];
  endfunction : iec_of

  // ---------------------------------------------------------------
  // request sources and channel requests
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      req_s1_q <= REG_RST;
      req_s2_q <= REG_RST;
    end else begin
      req_s1_q <= XFER_SRC_REQ;
      req_s2_q <= req_s1_q;
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_req[c] = tec_of(gctl1_q, 2'(c)) &&
          (req_s2_q[ctrl_q[c][2:0]] || gctl2_q[ctrl_q[c][2:0]]);
    end
  end

  assign ai.req = ch_req;
  assign ai.go = (state_q == ST_DETECT);

  // ---------------------------------------------------------------
  // address and completion arithmetic
  // ---------------------------------------------------------------
  assign src_calc = addr_calc(src_h_q[ch_q], src_l_q[ch_q],
      ctrl_q[ch_q][CTRL_SRC_MODE_LSB +: 2], bcnt_q[ch_q]);
  assign dst_calc = addr_calc(dst_h_q[ch_q], dst_l_q[ch_q],
      ctrl_q[ch_q][CTRL_DST_MODE_LSB +: 2], bcnt_q[ch_q]);
  assign seq_inc = (state_q == ST_LATCH) || (state_q == ST_HLATCH);
  assign seq_chk = (state_q == ST_DWR) || (state_q == ST_HDWR);
  // [RQ8] length minus count
  assign diff_zero = ((blen_q[ch_q] - bcnt_q[ch_q]) == REG_RST);

  // ---------------------------------------------------------------
  // apb slave, one wait state
  // ---------------------------------------------------------------
  assign apb_acc = PSEL && PENABLE;
  assign apb_wr = apb_acc && pready_q && PWRITE;
  assign idx = PADDR[9:2];
  assign wbyte = PWDATA[7:0];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      prdata_q <= RDATA_RST;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_acc && !pready_q;
      pslverr_q <= apb_acc && !pready_q && ((PADDR[1:0] != 2'h0) ||
          (PADDR[11:10] != 2'h0) || !(is_chan(idx) ||
          (idx >= IDX_GCTL1 && idx <= IDX_GCTL2)) ||
          (is_chan(idx) && sub_of(idx) == SUB_BLEN + 8'h01));
      prdata_q <= RDATA_RST;
      if (apb_acc && !pready_q && !PWRITE) begin
        if (idx == IDX_GCTL1) begin
          prdata_q[7:0] <= gctl1_q;
        end else if (idx == IDX_GSTAT) begin
          prdata_q[7:0] <= gstat_q;
        end else if (idx == IDX_GCTL2) begin
          prdata_q[7:0] <= gctl2_q;
        end else if (is_chan(idx)) begin
          case (sub_of(idx))
            8'h00: prdata_q[7:0] <= src_h_q[chan_of(idx)];
            SUB_SRC_L: prdata_q[7:0] <= src_l_q[chan_of(idx)];
            SUB_DST_H: prdata_q[7:0] <= dst_h_q[chan_of(idx)];
            SUB_DST_L: prdata_q[7:0] <= dst_l_q[chan_of(idx)];
            SUB_CTRL: prdata_q[7:0] <= ctrl_q[chan_of(idx)];
            SUB_BLEN: prdata_q[7:0] <= blen_q[chan_of(idx)];
            SUB_BCNT: prdata_q[7:0] <= bcnt_q[chan_of(idx)];
            default: prdata_q[7:0] <= REG_RST;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // channel registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (int c = 0; c < NUM_CH; c++) begin
        src_h_q[c] <= REG_RST;
        src_l_q[c] <= REG_RST;
        dst_h_q[c] <= REG_RST;
        dst_l_q[c] <= REG_RST;
        ctrl_q[c] <= REG_RST;
        blen_q[c] <= REG_RST;
        bcnt_q[c] <= REG_RST;
      end
    end else begin
      if (apb_wr && is_chan(idx)) begin
        case (sub_of(idx))
          8'h00: src_h_q[chan_of(idx)] <= wbyte;
          SUB_SRC_L: src_l_q[chan_of(idx)] <= wbyte;
          SUB_DST_H: dst_h_q[chan_of(idx)] <= wbyte;
          SUB_DST_L: dst_l_q[chan_of(idx)] <= wbyte;
          SUB_CTRL: ctrl_q[chan_of(idx)] <= wbyte;
          SUB_BLEN: blen_q[chan_of(idx)] <= wbyte;
          SUB_BCNT: bcnt_q[chan_of(idx)] <= wbyte;
          default: ;
        endcase
      end
      // [RQ7] count moved byte
      if (seq_inc) begin
        bcnt_q[ch_q] <= bcnt_q[ch_q] + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // global control and status
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      gctl1_q <= REG_RST;
      gstat_q <= REG_RST;
      gctl2_q <= REG_RST;
    end else begin
      if (apb_wr && idx == IDX_GCTL1) begin
        gctl1_q <= wbyte;
      end
      if (apb_wr && idx == IDX_GCTL2) begin
        gctl2_q <= wbyte;
      end
      if (apb_wr && idx == IDX_GSTAT) begin
        gstat_q <= {wbyte[7:3], gstat_q[2:0] & wbyte[2:0]};
      end
      // [RQ9] completion clears enable
      if (seq_chk && diff_zero) begin
        gctl1_q[{ch_q, 1'b1}] <= 1'b0;
        gstat_q[GSTAT_IFC_LSB + 32'(ch_q)] <= 1'b1;
      end
    end
  end

  // [RQ10] flagged and enabled raises irq
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(gstat_q[2:0] & {gctl1_q[4], gctl1_q[2], gctl1_q[0]});
    end
  end

  // ---------------------------------------------------------------
  // transfer state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      // [RQ4] detect, arbitrate, control
      ST_IDLE: state_d = (|ch_req) ? ST_DETECT : ST_IDLE;
      ST_DETECT: state_d = ST_ARB;
      ST_ARB: state_d = ai.gnt_vld ? ST_CTRL : ST_REL_D;
      ST_CTRL: state_d = ST_SCALC;
      ST_SCALC: state_d = ST_SRD;
      ST_SRD: state_d = ST_LATCH;
      ST_LATCH: state_d = ST_DWR;
      ST_DWR: state_d = ST_WDRV;
      // [RQ19] word adds four states
      ST_WDRV: state_d = word_q ? ST_HSRD : ST_REL_A;
      ST_HSRD: state_d = ST_HLATCH;
      ST_HLATCH: state_d = ST_HDWR;
      ST_HDWR: state_d = ST_HWDRV;
      ST_HWDRV: state_d = ST_REL_A;
      ST_REL_A: state_d = ST_REL_D;
      ST_REL_D: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      ch_q <= 2'h0;
      word_q <= 1'b0;
      src_tmp_q <= 16'h0000;
      dst_tmp_q <= 16'h0000;
      data_tmp_q <= REG_RST;
    end else begin
      state_q <= state_d;
      case (state_q)
        ST_CTRL: begin
          ch_q <= ai.gnt_ch;
          // [RQ20] byte or word per channel
          word_q <= ctrl_q[ai.gnt_ch][CTRL_BWS_BIT];
        end
        // [RQ5] [RQ13] latch source address
        ST_SCALC: src_tmp_q <= src_calc;
        // [RQ6] latch destination address
        ST_SRD: dst_tmp_q <= dst_calc;
        // [RQ7] [RQ14] latch read data
        ST_LATCH: data_tmp_q <= DATA_BUS_IN;
        // [RQ15] high byte source address
        ST_WDRV: begin
          if (word_q) begin
            src_tmp_q <= src_calc;
          end
        end
        // [RQ16] high destination, then data
        ST_HSRD: dst_tmp_q <= dst_calc;
        ST_HLATCH: data_tmp_q <= DATA_BUS_IN;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // cpu bus drive, registered from next state
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      addr_q <= 16'h0000;
      addr_oe_q <= 1'b0;
      rw_q <= 1'b1;
    end else begin
      // [RQ1] [RQ12] [RQ18] own then release address
      addr_oe_q <= (state_d inside {ST_SRD, ST_LATCH, ST_DWR, ST_WDRV,
          ST_HSRD, ST_HLATCH, ST_HDWR, ST_HWDRV});
      // [RQ8] [RQ14] [RQ17] write phase
      rw_q <= !(state_d inside {ST_DWR, ST_WDRV, ST_HDWR, ST_HWDRV});
      if (state_d == ST_SRD || state_d == ST_HSRD) begin
        addr_q <= src_calc;
      end else if (state_d == ST_DWR || state_d == ST_HDWR) begin
        addr_q <= dst_tmp_q;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      data_q <= REG_RST;
      data_oe_q <= 1'b0;
    end else begin
      // [RQ11] [RQ18] drive write data
      data_oe_q <= (state_d inside {ST_WDRV, ST_HWDRV, ST_REL_A});
      if (state_d == ST_WDRV || state_d == ST_HWDRV) begin
        data_q <= data_tmp_q;
      end
    end
  end

  // [RQ2] [RQ3] [RQ22] clock stop enable flop
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      clk_stop_q <= 1'b0;
    end else begin
      clk_stop_q <= (state_d != ST_IDLE);
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign ADDR_BUS_OUT = addr_q;
  assign ADDR_BUS_OE = addr_oe_q;
  assign RW_OUT = rw_q;
  assign RW_OE = addr_oe_q;
  assign DATA_BUS_OUT = data_q;
  assign DATA_BUS_OE = data_oe_q;
  assign CPU_CLK_STOP = clk_stop_q;
  assign CPU_IRQ = irq_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  bus_owned_a: assert property (ADDR_BUS_OE |-> CPU_CLK_STOP) // [RQ1]
    else $error("bus taken while cpu clock runs");
  clk_hold_a: assert property (state_q == ST_CTRL |-> // [RQ2]
      CPU_CLK_STOP[*8])
    else $error("cpu clock released early");
  cpu_resume_a: assert property ($fell(CPU_CLK_STOP) |-> // [RQ3]
      !ADDR_BUS_OE && !DATA_BUS_OE && !RW_OE)
    else $error("cpu resumed with bus still driven");
  src_read_a: assert property (state_q == ST_SRD |-> // [RQ6]
      RW_OE && RW_OUT && ADDR_BUS_OUT == src_tmp_q)
    else $error("source read phase wrong");
  dst_write_a: assert property (state_q == ST_DWR |-> // [RQ8]
      RW_OE && !RW_OUT && ADDR_BUS_OUT == dst_tmp_q)
    else $error("destination write phase wrong");
  tec_clear_a: assert property (seq_chk && diff_zero |=> // [RQ9]
      !tec_of(gctl1_q, ch_q))
    else $error("channel enable not cleared");
  irq_raise_a: assert property (seq_chk && diff_zero && // [RQ10]
      iec_of(gctl1_q, ch_q) && !apb_wr |-> ##2 CPU_IRQ)
    else $error("completion interrupt missing");
  data_drive_a: assert property (state_q == ST_WDRV |-> // [RQ11]
      DATA_BUS_OE && DATA_BUS_OUT == data_tmp_q)
    else $error("write data not driven");
  bus_release_a: assert property (state_q == ST_REL_A |-> // [RQ12]
      !ADDR_BUS_OE && DATA_BUS_OE ##1 !DATA_BUS_OE)
    else $error("bus release order wrong");
  byte_len_a: assert property (state_q == ST_CTRL && // [RQ19]
      !ctrl_q[ai.gnt_ch][CTRL_BWS_BIT] |-> ##7 state_q == ST_REL_D)
    else $error("byte transfer length wrong");
  word_len_a: assert property (state_q == ST_CTRL && // [RQ19]
      ctrl_q[ai.gnt_ch][CTRL_BWS_BIT] |-> ##11 state_q == ST_REL_D)
    else $error("word transfer length wrong");

  byte_xfer_c: cover property (state_q == ST_WDRV && !word_q);
  word_xfer_c: cover property (state_q == ST_HWDRV);
  done_irq_c: cover property ($rose(CPU_IRQ));
endmodule : dbts_seq

// >>> dv/dbts_cpu_model.sv
// cpu side bus partner: byte memory behind the shared bus
`timescale 1ns/1ps
module dbts_cpu_model (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic addr_oe,
  input wire logic rw,
  input wire logic [7:0] wdata,
  input wire logic data_oe,
  output logic [7:0] rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h5a;
  assign rdata = (addr_oe && rw) ? mem[addr[7:0]] : ~last_q;
  always @(posedge clk) begin
    if (addr_oe && rw) begin
      last_q <= mem[addr[7:0]];
    end
    if (addr_oe && !rw && data_oe) begin
      mem[addr[7:0]] <= wdata;
    end
  end
endmodule : dbts_cpu_model

// >>> dv/tb_dma_bus_transfer_sequencer.sv
// self-checking bench for the dma transfer sequencer
`timescale 1ns/1ps
module tb_dma_bus_transfer_sequencer;
  import dbts_pkg::*;
  // ------------
  // signals and instances
  // ------------
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000;
  logic [7:0] XFER_SRC_REQ = 8'h00;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, ADDR_BUS_OE, RW_OUT, RW_OE, DATA_BUS_OE, err;
  logic [15:0] ADDR_BUS_OUT;
  logic [7:0] DATA_BUS_IN, DATA_BUS_OUT, v;
  logic [7:0] init_mem [256];
  logic CPU_CLK_STOP, CPU_IRQ;
  int failures = 0;
  int checks_done = 0;
  int seed = 32'h99ed;
  int run = 0;
  int aoe = 0;
  int doe = 0;
  int wr = 0;
  int runs[$];
  dbts_seq uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .XFER_SRC_REQ(XFER_SRC_REQ), .DATA_BUS_IN(DATA_BUS_IN),
    .ADDR_BUS_OUT(ADDR_BUS_OUT), .ADDR_BUS_OE(ADDR_BUS_OE),
    .RW_OUT(RW_OUT), .RW_OE(RW_OE), .DATA_BUS_OUT(DATA_BUS_OUT),
    .DATA_BUS_OE(DATA_BUS_OE), .CPU_CLK_STOP(CPU_CLK_STOP),
    .CPU_IRQ(CPU_IRQ));
  dbts_cpu_model u_cpu (.clk(SYS_CLK), .addr(ADDR_BUS_OUT),
    .addr_oe(ADDR_BUS_OE), .rw(RW_OUT), .wdata(DATA_BUS_OUT),
    .data_oe(DATA_BUS_OE), .rdata(DATA_BUS_IN));
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // shape of each stop: length, address, write and data owned cycles
  always @(negedge SYS_CLK) begin
    if (CPU_CLK_STOP === 1'b1) begin
      run++;
      aoe += (ADDR_BUS_OE === 1'b1 && RW_OE === 1'b1);
      wr += (RW_OE === 1'b1 && RW_OUT === 1'b0);
      doe += (DATA_BUS_OE === 1'b1);
    end else if (run > 0) begin
      runs.push_back(run * 4096 + aoe * 256 + wr * 16 + doe);
      run = 0;
      aoe = 0;
      wr = 0;
      doe = 0;
    end
  end
  // ------------
  // tasks
  // ------------
  task automatic summarize();
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      failures++;
      $display("wrong value at %0t: expected %h got %h", $time, e, a);
    end
  endtask : chk
  task automatic chk_pin(input logic e, input logic a);
    chk({31'h0, e}, {31'h0, a});
  endtask : chk_pin
  task automatic apb(input logic w, input logic [7:0] idx,
      input logic [7:0] wd);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {2'h0, idx, 2'h0};
    PWDATA <= {24'h000000, wd};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (n >= 40) failures++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : apb
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e,
      input logic ee);
    apb(1'b0, idx, 8'h00);
    chk({24'h000000, e}, rd);
    chk_pin(ee, err);
  endtask : rdc
  task automatic setup(input logic [7:0] b, input logic [7:0] s,
      input logic [7:0] d, input logic [7:0] c, input logic [7:0] bl);
    apb(1'b1, b, 8'h00);
    apb(1'b1, b + SUB_SRC_L, s);
    apb(1'b1, b + SUB_DST_H, 8'h00);
    apb(1'b1, b + SUB_DST_L, d);
    apb(1'b1, b + SUB_CTRL, c);
    apb(1'b1, b + SUB_BLEN, bl);
    apb(1'b1, b + SUB_BCNT, 8'h00);
  endtask : setup
  task automatic finish_ch(input logic [7:0] b, input logic [7:0] eg,
      input logic [7:0] s, input logic [7:0] d, input int n, input int nr,
      input int shape);
    int k;
    k = 0;
    do begin
      apb(1'b0, IDX_GCTL1, 8'h00);
      k++;
    end while (rd[7:0] !== eg && k < 100);
    repeat (20) @(posedge SYS_CLK);
    chk({24'h000000, eg}, rd);
    rdc(b + SUB_BCNT, 8'(n), 1'b0);
    for (int i = 0; i < n; i++) begin
      chk(init_mem[s + i], u_cpu.mem[d + i]);
    end
    chk(nr, runs.size());
    while (runs.size() > 0) begin
      chk(shape, runs.pop_front());
    end
  endtask : finish_ch
  // ------------
  // stimulus
  // ------------
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      init_mem[i] = 8'($random(seed));
      u_cpu.mem[i] = init_mem[i];
    end
    repeat (6) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    rdc(IDX_CH0_BCNT, 8'h00, 1'b0);
    rdc(IDX_GCTL1, 8'h00, 1'b0);
    rdc(IDX_GSTAT, 8'h00, 1'b0);
    apb(1'b1, 8'h3a, 8'hff);
    rdc(8'h3a, 8'h00, 1'b1);
    rdc(8'h4f, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      apb(1'b1, 8'(IDX_CH2_SRC_H + i), v);
      rdc(8'(IDX_CH2_SRC_H + i), v, 1'b0);
    end
    // byte mode, add count, software request on input 2
    setup(IDX_CH0_SRC_H, 8'h10, 8'h80, 8'h52, 8'h03);
    apb(1'b1, IDX_GCTL1, 8'h03);
    apb(1'b1, IDX_GCTL2, 8'h04);
    finish_ch(IDX_CH0_SRC_H, 8'h01, 8'h10, 8'h80, 3, 3, 32'ha422);
    chk_pin(1'b1, CPU_IRQ);
    rdc(IDX_GSTAT, 8'h01, 1'b0);
    apb(1'b1, IDX_GCTL2, 8'h00);
    apb(1'b1, IDX_GSTAT, 8'h00);
    repeat (4) @(posedge SYS_CLK);
    chk_pin(1'b0, CPU_IRQ);
    // word mode, two words, hardware request on input 5
    setup(IDX_CH1_SRC_H, 8'h20, 8'ha0, 8'h5d, 8'h04);
    apb(1'b1, IDX_GCTL1, 8'h08);
    XFER_SRC_REQ <= 8'h20;
    finish_ch(IDX_CH1_SRC_H, 8'h00, 8'h20, 8'ha0, 4, 2, 32'he843);
    XFER_SRC_REQ <= 8'h00;
    chk_pin(1'b0, CPU_IRQ);
    rdc(IDX_GSTAT, 8'h02, 1'b0);
    summarize();
  end
endmodule : tb_dma_bus_transfer_sequencer
